// ===== upm_top.sv
/*
 * Uncore performance monitor: eight general event counters, one fixed clock
 * counter, global control and status, address/opcode match filter, all
 * behind an AHB-Lite slave with zero wait states.
 * Assumes event sources and transactions are synchronous to hclk; each
 * event source offers eight sub-event lines per cycle.
 */
`timescale 1ns/1ps
`include "upm_map.svh"

module upm_top #(
    parameter int NUM_GP = 8,
    parameter int CNT_W = 48,
    parameter int NUM_CORES = 4,
    parameter int NUM_SRC = 16,
    parameter logic [7:0] MATCH_EVENT = 8'hFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_SRC-1:0][7:0] event_lanes,
    input wire upm_pkg::upm_txn_t txn,
    output logic [NUM_GP-1:0] occupancy_clear,
    output logic [NUM_CORES-1:0] core_irq
);
    import upm_pkg::*;

    localparam int AW = `UPM_ADDR_W;

    logic dp_wr_q;
    logic [AW-1:0] dp_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_val;
    logic [63:0] gctrl_q;
    logic [63:0] filt_q;
    logic [31:0] fixctl_q;
    logic [CNT_W-1:0] fix_cnt_q;
    logic [NUM_GP-1:0] ovf_gp_q;
    logic ovf_fc_q;
    logic pend_q;
    logic chg_q;
    logic [NUM_CORES-1:0] core_irq_q;
    logic [NUM_GP-1:0] occ_q;
    upm_evsel_t evsel_q [NUM_GP];
    logic [CNT_W-1:0] cnt_q [NUM_GP];
    logic [NUM_GP-1:0] gp_wrap;
    logic [NUM_GP-1:0] gp_wr;
    logic fc_wrap;
    logic fc_wr;
    logic irq_evt;
    logic addr_hit;
    logic op_hit;
    logic match_hit;
    logic [63:0] clr_vec;
    logic [63:0] stat_vec;

    wire logic ap = hsel && htrans[1] && hready;
    wire logic wr_ctrl_lo = dp_wr_q && dp_addr_q == `UPM_OFF_CTRL_LO;
    wire logic wr_ctrl_hi = dp_wr_q && dp_addr_q == `UPM_OFF_CTRL_HI;
    wire logic wr_clr_lo = dp_wr_q && dp_addr_q == `UPM_OFF_CLR_LO;
    wire logic wr_clr_hi = dp_wr_q && dp_addr_q == `UPM_OFF_CLR_HI;
    wire logic wr_fix_lo = dp_wr_q && dp_addr_q == `UPM_OFF_FIXCNT_LO;
    wire logic wr_fix_hi = dp_wr_q && dp_addr_q == `UPM_OFF_FIXCNT_HI;
    wire logic fc_en = fixctl_q[`UPM_FC_EN] && gctrl_q[`UPM_GC_FC_EN];
    wire logic [NUM_CORES-1:0] route =
        gctrl_q[`UPM_GC_ROUTE_LSB +: NUM_CORES];

    // Zero wait states: a read is sampled in its address phase, so its
    // data stand at the end of the single data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign core_irq = core_irq_q;
    assign occupancy_clear = occ_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= '0;
        end else if (hready) begin
            // Only whole-word writes are taken; other sizes are ignored.
            dp_wr_q <= ap && hwrite && hsize == 3'b010;
            dp_addr_q <= haddr[AW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= `UPM_RST_32;
        end else if (ap && !hwrite) begin
            rdata_q <= rd_val;
        end
    end

    assign stat_vec = {chg_q, 1'b0, pend_q, 28'h000_0000, ovf_fc_q,
        24'h00_0000, 8'(ovf_gp_q)};

    always_comb begin
        rd_val = `UPM_RST_32;
        unique case (haddr[AW-1:0])
            `UPM_OFF_CTRL_LO: rd_val = gctrl_q[31:0];
            `UPM_OFF_CTRL_HI: rd_val = gctrl_q[63:32];
            `UPM_OFF_STAT_LO: rd_val = stat_vec[31:0];
            `UPM_OFF_STAT_HI: rd_val = stat_vec[63:32];
            `UPM_OFF_FIXCTL: rd_val = fixctl_q;
            `UPM_OFF_FILT_LO: rd_val = filt_q[31:0];
            `UPM_OFF_FILT_HI: rd_val = filt_q[63:32];
            `UPM_OFF_FIXCNT_LO: rd_val = fix_cnt_q[31:0];
            `UPM_OFF_FIXCNT_HI: rd_val = 32'(fix_cnt_q[CNT_W-1:32]);
            default: rd_val = `UPM_RST_32;
        endcase
        for (int i = 0; i < NUM_GP; i++) begin
            if (haddr[AW-1:0] == `UPM_OFF_EVSEL_BASE
                    + AW'(i * `UPM_EVSEL_STRIDE)) begin
                rd_val = evsel_q[i];
            end
            if (haddr[AW-1:0] == `UPM_OFF_CNT_BASE
                    + AW'(i * `UPM_CNT_STRIDE)) begin
                rd_val = cnt_q[i][31:0];
            end
            if (haddr[AW-1:0] == `UPM_OFF_CNT_BASE
                    + AW'(i * `UPM_CNT_STRIDE + 4)) begin
                rd_val = 32'(cnt_q[i][CNT_W-1:32]);
            end
        end
    end

    // A counter's overflow reaches the cores only with its own interrupt enable set.
    always_comb begin
        irq_evt = fc_wrap && fixctl_q[`UPM_FC_PMI];
        for (int i = 0; i < NUM_GP; i++) begin
            irq_evt = irq_evt || (gp_wrap[i] && evsel_q[i].overflow_interrupt_enable);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gctrl_q <= `UPM_RST_64;
        end else begin
            if (wr_ctrl_lo) begin
                gctrl_q[31:0] <= hwdata;
            end
            if (wr_ctrl_hi) begin
                gctrl_q[63:32] <= hwdata;
            end
            // Freeze clears the enables themselves, so counting resumes only
            // when software writes them again; it wins over a same-cycle write.
            if (irq_evt && gctrl_q[`UPM_GC_FRZ]) begin
                gctrl_q[NUM_GP-1:0] <= '0;
                gctrl_q[`UPM_GC_FC_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fixctl_q <= `UPM_RST_32;
            filt_q <= `UPM_RST_64;
        end else if (dp_wr_q) begin
            if (dp_addr_q == `UPM_OFF_FIXCTL) begin
                fixctl_q <= hwdata;
            end
            if (dp_addr_q == `UPM_OFF_FILT_LO) begin
                filt_q[31:0] <= hwdata;
            end
            if (dp_addr_q == `UPM_OFF_FILT_HI) begin
                filt_q[63:32] <= hwdata;
            end
        end
    end

    // Address/opcode filter feeding the match event unit.
    always_comb begin
        addr_hit = txn.addr[`UPM_FI_ADDR_MSB:`UPM_FI_ADDR_LSB]
            == filt_q[`UPM_FI_ADDR_MSB:`UPM_FI_ADDR_LSB];
        op_hit = txn.opcode == filt_q[`UPM_FI_OPC_LSB +: 4]
            && txn.mclass == filt_q[`UPM_FI_CLS_LSB +: 4];
        unique case (upm_match_sel_t'(filt_q[`UPM_FI_MS_LSB +: 3]))
            UPM_MS_ADDR_E: match_hit = txn.valid && addr_hit;
            UPM_MS_OPC_E: match_hit = txn.valid && op_hit;
            UPM_MS_EITHER_E: match_hit = txn.valid && (addr_hit || op_hit);
            UPM_MS_BOTH_E: match_hit = txn.valid && addr_hit && op_hit;
            default: match_hit = 1'b0;
        endcase
    end

    generate
        for (genvar g = 0; g < NUM_GP; g++) begin : g_ctr
            localparam logic [AW-1:0] SEL_OFF =
                `UPM_OFF_EVSEL_BASE + AW'(g * `UPM_EVSEL_STRIDE);
            localparam logic [AW-1:0] CNT_OFF =
                `UPM_OFF_CNT_BASE + AW'(g * `UPM_CNT_STRIDE);
            logic [7:0] lanes;
            logic [3:0] raw;
            logic cond;
            logic prev_q;
            logic [3:0] step;
            logic [CNT_W:0] sum;
            logic run;

            always_comb begin
                lanes = 8'h00;
                if (evsel_q[g].sel == MATCH_EVENT) begin
                    lanes = {7'h00, match_hit};
                end else if (32'(evsel_q[g].sel) < NUM_SRC) begin
                    lanes = event_lanes[evsel_q[g].sel]
                        & evsel_q[g].umask;
                end
                raw = 4'h0;
                for (int b = 0; b < 8; b++) begin
                    raw = raw + 4'(lanes[b]);
                end
                if (evsel_q[g].cmask != 8'h00) begin
                    cond = evsel_q[g].threshold_invert
                        ? ({4'h0, raw} < evsel_q[g].cmask)
                        : ({4'h0, raw} >= evsel_q[g].cmask);
                end else begin
                    cond = raw != 4'h0;
                end
                if (evsel_q[g].edge_det) begin
                    step = 4'(cond && !prev_q);
                end else if (evsel_q[g].cmask != 8'h00) begin
                    step = 4'(cond);
                end else begin
                    step = raw;
                end
                run = evsel_q[g].en && gctrl_q[g];
                sum = {1'b0, cnt_q[g]} + (CNT_W + 1)'(step);
            end

            assign gp_wr[g] = dp_wr_q
                && (dp_addr_q == CNT_OFF || dp_addr_q == CNT_OFF + AW'(4));
            assign gp_wrap[g] = run && sum[CNT_W] && !gp_wr[g];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= cond;
                end
            end

            // A software write to the counter wins over counting.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q[g] <= '0;
                end else if (dp_wr_q && dp_addr_q == CNT_OFF) begin
                    cnt_q[g][31:0] <= hwdata;
                end else if (dp_wr_q && dp_addr_q == CNT_OFF + AW'(4)) begin
                    cnt_q[g][CNT_W-1:32] <= hwdata[CNT_W-33:0];
                end else if (run) begin
                    cnt_q[g] <= sum[CNT_W-1:0];
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    evsel_q[g] <= `UPM_RST_32;
                    occ_q[g] <= 1'b0;
                end else begin
                    occ_q[g] <= dp_wr_q && dp_addr_q == SEL_OFF
                        && hwdata[`UPM_ES_OCC];
                    if (dp_wr_q && dp_addr_q == SEL_OFF) begin
                        evsel_q[g] <= hwdata & ~(32'h1 << `UPM_ES_OCC);
                    end
                end
            end
        end
    endgenerate

    assign fc_wr = wr_fix_lo || wr_fix_hi;
    assign fc_wrap = fc_en && !fc_wr && &fix_cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fix_cnt_q <= '0;
        end else if (wr_fix_lo) begin
            fix_cnt_q[31:0] <= hwdata;
        end else if (wr_fix_hi) begin
            fix_cnt_q[CNT_W-1:32] <= hwdata[CNT_W-33:0];
        end else if (fc_en) begin
            fix_cnt_q <= fix_cnt_q + CNT_W'(1);
        end
    end

    // Status: a set in the same cycle as its clear wins.
    assign clr_vec = {wr_clr_hi ? hwdata : 32'h0, wr_clr_lo ? hwdata : 32'h0};

    logic [NUM_GP-1:0] ovf_gp_d;
    logic ovf_fc_d;
    logic pend_d;

    always_comb begin
        ovf_gp_d = (ovf_gp_q & ~clr_vec[NUM_GP-1:0]) | gp_wrap;
        ovf_fc_d = (ovf_fc_q && !clr_vec[`UPM_ST_FC]) || fc_wrap;
        pend_d = (pend_q && !clr_vec[`UPM_ST_PMI]) || irq_evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_gp_q <= '0;
            ovf_fc_q <= 1'b0;
            pend_q <= 1'b0;
            chg_q <= 1'b0;
            core_irq_q <= '0;
        end else begin
            ovf_gp_q <= ovf_gp_d;
            ovf_fc_q <= ovf_fc_d;
            pend_q <= pend_d;
            chg_q <= (chg_q && !clr_vec[`UPM_ST_CHG])
                || ovf_gp_d != ovf_gp_q || ovf_fc_d != ovf_fc_q
                || pend_d != pend_q;
            core_irq_q <= pend_d ? route : '0;
        end
    end

    property p_gp_hold;
        @(posedge hclk) disable iff (!hresetn)
        !gctrl_q[0] && !gp_wr[0] |=> cnt_q[0] == $past(cnt_q[0]);
    endproperty
    a_gp_hold: assert property (p_gp_hold)
        else $error("general counter 0 moved while disabled");

    property p_fix_step;
        @(posedge hclk) disable iff (!hresetn)
        fc_en && !fc_wr |=> fix_cnt_q == $past(fix_cnt_q) + CNT_W'(1);
    endproperty
    a_fix_step: assert property (p_fix_step)
        else $error("fixed counter did not advance by one");

    property p_fix_hold;
        @(posedge hclk) disable iff (!hresetn)
        !gctrl_q[`UPM_GC_FC_EN] && !fc_wr ##1 !fc_wr |-> $stable(fix_cnt_q);
    endproperty
    a_fix_hold: assert property (p_fix_hold)
        else $error("fixed counter moved while globally disabled");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        irq_evt && gctrl_q[`UPM_GC_FRZ]
            |=> gctrl_q[NUM_GP-1:0] == '0 && !gctrl_q[`UPM_GC_FC_EN]
            ##1 (gctrl_q[0] == 1'b0 || $past(wr_ctrl_lo));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counters kept running after a freeze");

    property p_ovf_set;
        @(posedge hclk) disable iff (!hresetn)
        gp_wrap[0] |=> ovf_gp_q[0] && chg_q;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow did not set its status bit");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_clr_hi && hwdata[`UPM_ST_PMI - 32] && !irq_evt |=> !pend_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("pending flag survived a clear");

    property p_chg;
        @(posedge hclk) disable iff (!hresetn)
        $changed(ovf_fc_q) || $changed(pend_q) |-> chg_q;
    endproperty
    a_chg: assert property (p_chg)
        else $error("status change not flagged");

    property p_route;
        @(posedge hclk) disable iff (!hresetn)
        irq_evt && !wr_ctrl_hi |=> core_irq == route;
    endproperty
    a_route: assert property (p_route)
        else $error("interrupt not routed to selected cores");

    property p_occ;
        @(posedge hclk) disable iff (!hresetn)
        dp_wr_q && dp_addr_q == `UPM_OFF_EVSEL_BASE && hwdata[`UPM_ES_OCC]
            |=> occupancy_clear[0] && !evsel_q[0].occ_rst
            ##1 !occupancy_clear[0] || $past(dp_wr_q);
    endproperty
    a_occ: assert property (p_occ)
        else $error("occupancy clear pulse or readback wrong");

endmodule // upm_top

// ===== upm_map.svh
/*
 * Register offsets, field positions, reset values and encodings of the
 * uncore performance monitor.
 * Assumes a 32-bit AHB-Lite slave port with byte addresses in the low bits.
 */
`ifndef UPM_MAP_SVH
`define UPM_MAP_SVH

`define UPM_ADDR_W 8
`define UPM_OFF_CTRL_LO 8'h00
`define UPM_OFF_CTRL_HI 8'h04
`define UPM_OFF_STAT_LO 8'h08
`define UPM_OFF_STAT_HI 8'h0C
`define UPM_OFF_CLR_LO 8'h10
`define UPM_OFF_CLR_HI 8'h14
`define UPM_OFF_FIXCTL 8'h18
`define UPM_OFF_FILT_LO 8'h1C
`define UPM_OFF_FILT_HI 8'h20
`define UPM_OFF_FIXCNT_LO 8'h24
`define UPM_OFF_FIXCNT_HI 8'h28
`define UPM_OFF_EVSEL_BASE 8'h40
`define UPM_OFF_CNT_BASE 8'h80
`define UPM_EVSEL_STRIDE 4
`define UPM_CNT_STRIDE 8

`define UPM_GC_FC_EN 32
`define UPM_GC_ROUTE_LSB 48
`define UPM_GC_FRZ 63
`define UPM_ST_FC 32
`define UPM_ST_PMI 61
`define UPM_ST_CHG 63

`define UPM_ES_SEL_LSB 0
`define UPM_ES_MASK_LSB 8
`define UPM_ES_OCC 17
`define UPM_ES_EDGE 18
`define UPM_ES_PMI 20
`define UPM_ES_EN 22
`define UPM_ES_INV 23
`define UPM_ES_CMASK_LSB 24
`define UPM_FC_EN 0
`define UPM_FC_PMI 2

`define UPM_FI_ADDR_LSB 3
`define UPM_FI_ADDR_MSB 39
`define UPM_FI_OPC_LSB 40
`define UPM_FI_CLS_LSB 44
`define UPM_FI_MS_LSB 61

`define UPM_MS_OFF 3'b000
`define UPM_MS_ADDR 3'b100
`define UPM_MS_OPC 3'b010
`define UPM_MS_EITHER 3'b110
`define UPM_MS_BOTH 3'b001

`define UPM_RST_64 64'h0000_0000_0000_0000
`define UPM_RST_32 32'h0000_0000

`endif

// ===== upm_pkg.sv
/*
 * Types shared by the uncore performance monitor.
 * Assumes upm_map.svh is on the include path.
 */
`include "upm_map.svh"

package upm_pkg;

    // Encodings of the filter's match selection field.
    typedef enum logic [2:0] {
        UPM_MS_OFF_E = `UPM_MS_OFF,
        UPM_MS_ADDR_E = `UPM_MS_ADDR,
        UPM_MS_OPC_E = `UPM_MS_OPC,
        UPM_MS_EITHER_E = `UPM_MS_EITHER,
        UPM_MS_BOTH_E = `UPM_MS_BOTH
    } upm_match_sel_t;

    // One transaction seen by the home logic in this cycle.
    typedef struct packed {
        logic valid;
        logic [39:0] addr;
        logic [3:0] opcode;
        logic [3:0] mclass;
    } upm_txn_t;

    // Fields of an event select register.
    typedef struct packed {
        logic [7:0] cmask;
        logic threshold_invert;
        logic en;
        logic rsv21;
        logic overflow_interrupt_enable;
        logic rsv19;
        logic edge_det;
        logic occ_rst;
        logic rsv16;
        logic [7:0] umask;
        logic [7:0] sel;
    } upm_evsel_t;

endpackage : upm_pkg

// ===== upm_core_model.sv
/* Model of the four cores that receive the overflow interrupt lines.
   Assumes core_irq is a registered level, synchronous to hclk. */
`timescale 1ns/1ps
module upm_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] core_irq,
    input wire logic [3:0] irq_enable,
    output logic [3:0] taken_q
);
    logic [3:0] irq_q;
    // A core takes the interrupt only with its own delivery enable set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 4'h0;
            taken_q <= 4'h0;
        end else begin
            irq_q <= core_irq;
            taken_q <= taken_q | (core_irq & ~irq_q & irq_enable);
        end
    end
endmodule // upm_core_model

// ===== upm_top_tb_top.sv
/* Self-checking bench for the uncore performance monitor.
   Assumes a zero-wait AHB-Lite slave and the core model beside it. */
`timescale 1ns/1ps
module upm_top_tb_top;
    import upm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0][7:0] event_lanes = '0;
    upm_txn_t txn = '0;
    logic [7:0] occupancy_clear;
    logic [3:0] core_irq;
    logic [3:0] taken_q;
    logic [31:0] lfsr_q = 32'hAB67_5BAF;
    logic [31:0] exp_q[$];
    logic [7:0] rd_addr_q;
    logic rd_dp_q = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int occ_pulses = 0;
    int cycles = 0;
    // Event select, idle lane value and expected count per case.
    logic [47:0] tab[7] = '{48'h0042FF00_00_0C, 48'h0240FF00_00_04,
        48'h04C0FF00_0F_04, 48'h0044FF00_00_01, 48'h0000FF00_00_00,
        48'h00400100_00_04, 48'h0040FF01_00_00};

    upm_top i_upm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .event_lanes(event_lanes),
        .txn(txn), .occupancy_clear(occupancy_clear), .core_irq(core_irq));
    upm_core_model i_upm_core_model (.hclk(hclk), .hresetn(hresetn),
        .core_irq(core_irq), .irq_enable(4'h3), .taken_q(taken_q));

    always #25 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // The given lane value stands for four cycles, then the idle value returns.
    task automatic pulse(input logic [7:0] v, input logic [7:0] idle);
        @(posedge hclk);
        event_lanes[0] <= v;
        repeat (4) @(posedge hclk);
        event_lanes[0] <= idle;
    endtask

    // Random transactions keep the filter path busy while it is off.
    always @(posedge hclk) begin
        lfsr_q <= lfsr(lfsr_q);
        txn <= {1'b1, lfsr_q[7:0], lfsr_q, lfsr_q[11:4]};
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (occupancy_clear[0] === 1'b1)
            occ_pulses <= occ_pulses + 1;
        if (rd_dp_q)
            check(hrdata, exp_q.pop_front(), $sformatf("hrdata_%h", rd_addr_q));
        rd_dp_q <= hsel && htrans[1] && !hwrite && hready;
        rd_addr_q <= haddr[7:0];
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0);
        r = lfsr_q;
        wr(8'h1C, r);
        rd(8'h1C, r);
        wr(8'h90, r);
        rd(8'h90, r);
        wr(8'h40, 32'h0040_FF00);
        pulse(8'h07, 8'h00);
        rd(8'h80, 32'h0);
        wr(8'h00, 32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            @(posedge hclk);
            event_lanes[0] <= tab[i][15:8];
            wr(8'h40, tab[i][47:16]);
            wr(8'h80, 32'h0);
            pulse(8'h07, tab[i][15:8]);
            rd(8'h80, {24'h0, tab[i][7:0]});
            rd(8'h40, tab[i][47:16] & 32'hFFFD_FFFF);
        end
        wr(8'h28, 32'h0000_FFFF);
        wr(8'h24, 32'hFFFF_FFF0);
        wr(8'h18, 32'h0000_0005);
        wr(8'h04, 32'h8005_0001);
        repeat (40) @(posedge hclk);
        check({28'h0, core_irq}, 32'h5, "core_irq");
        wr(8'h14, 32'h0);
        rd(8'h0C, 32'hA000_0001);
        rd(8'h04, 32'h8005_0000);
        wr(8'h14, 32'h2000_0001);
        rd(8'h0C, 32'h8000_0000);
        check({28'h0, core_irq}, 32'h0, "core_irq");
        wr(8'h14, 32'h8000_0000);
        rd(8'h0C, 32'h0);
        // Counter 0 counts idle cycles below a threshold of one, then wraps.
        wr(8'h40, 32'h01D0_FF00);
        wr(8'h84, 32'h0000_FFFF);
        wr(8'h80, 32'hFFFF_FFF0);
        wr(8'h00, 32'h0000_0001);
        repeat (40) @(posedge hclk);
        check({28'h0, core_irq}, 32'h5, "core_irq_gp");
        rd(8'h08, 32'h0000_0001);
        rd(8'h00, 32'h0);
        @(posedge hclk);
        check(occ_pulses, 32'h1, "occupancy_clear");
        check({28'h0, taken_q}, 32'h1, "taken_q");
        stop_test();
    end
endmodule // upm_top_tb_top
